// ---- logic/flash_spi_map.svh ----
// constants of the serial flash front end: opcodes, status layout, timing
// assumes it is included by the front end module
`ifndef FLASH_SPI_MAP_SVH
`define FLASH_SPI_MAP_SVH

`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ       8'h05
`define OP_STATUS_WRITE      8'h01
`define OP_ARRAY_READ        8'h03
`define OP_ARRAY_FAST_READ   8'h0B
`define OP_PAGE_PROGRAM      8'h02
`define OP_PAGE_WIPE         8'h81
`define OP_SECTOR_WIPE       8'hD8
`define OP_FULL_WIPE         8'hC7
`define OP_SOFT_GUARD_ENTER  8'hB9
`define OP_SOFT_GUARD_EXIT   8'hAB

`define ST_HW_GUARD_BIT      7
`define ST_LEVEL_HI_BIT      3
`define ST_LEVEL_LO_BIT      2
`define ST_WRITE_LATCH_BIT   1
`define ST_BUSY_BIT          0
`define STATUS_RESET         8'h00

`define PROT_QUARTER_FROM    18'h30000
`define PROT_HALF_FROM       18'h20000
`define PROT_ALL_FROM        18'h00000

`define CLK_MHZ              250
`define PROG_TIME_MS         8
`define BUSY_CYCLES_DEFAULT  (`PROG_TIME_MS * `CLK_MHZ * 1000)

`endif

// ---- logic/flash_spi_pkg.sv ----
// types shared by the serial flash front end
// assumes the map header sits beside it
package flash_spi_pkg;

    // sequence position inside one selected frame
    typedef enum logic [4:0] {
        ST_OPCODE   = 5'b00001,
        ST_STAT_OUT = 5'b00010,
        ST_STAT_IN  = 5'b00100,
        ST_IGNORE   = 5'b01000,
        ST_DEAD     = 5'b10000
    } seqState_t;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic selectN;
        logic sck;
        logic mosi;
        logic pauseN;
        logic guardN;
    } pinSample_t;

endpackage : flash_spi_pkg

// ---- logic/pin_sync.sv ----
// two flip-flop synchroniser for a group of pins
// assumes a synchronous-release active-low reset on the same clock
module pin_sync #(
    parameter int                 WIDTH    = 1,
    parameter logic [WIDTH-1:0]   RST_VAL  = '0
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : pin_sync

// ---- logic/serial_flash_spi_front_end.sv ----
// serial front end of a small serial flash: opcode intake, pause, status byte
// assumes the spi pins arrive unsynchronised; the system clock far outruns sck
`include "flash_spi_map.svh"
module serial_flash_spi_front_end #(
    parameter int BUSY_CYCLES = `BUSY_CYCLES_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        select_n,
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic        pause_n,
    input  wire logic        write_guard_n,
    output logic             miso,
    output logic             misoOe,
    output logic [7:0]       statusByte,
    output logic             arrayStart,
    output logic [7:0]       arrayOpcode,
    output logic             protectAny,
    output logic [17:0]      protectFrom,
    output logic             softGuard
);
    localparam int CW = $clog2(BUSY_CYCLES + 1);

    // refuse a busy time of less than one cycle
    if (BUSY_CYCLES < 1)
    begin : g_busy_check
        $error("BUSY_CYCLES must be at least one");
    end

    localparam flash_spi_pkg::pinSample_t PIN_RST = '{
        selectN: 1'b1, sck: 1'b0, mosi: 1'b0, pauseN: 1'b1, guardN: 1'b1};

    // compose the status byte
    function automatic logic [7:0] packStatus(
        input logic       guardEn,
        input logic [1:0] level,
        input logic       latch,
        input logic       busyFlag
    );
        logic [7:0] s;
        s = `STATUS_RESET;
        s[`ST_HW_GUARD_BIT]    = guardEn;
        s[`ST_LEVEL_HI_BIT]    = level[1];
        s[`ST_LEVEL_LO_BIT]    = level[0];
        s[`ST_WRITE_LATCH_BIT] = latch;
        s[`ST_BUSY_BIT]        = busyFlag;
        return s;
    endfunction : packStatus

    // lowest protected address for a level
    function automatic logic [17:0] levelFrom(input logic [1:0] level);
        logic [17:0] a;
        a = `PROT_ALL_FROM;
        unique case (level)
            2'b01: a = `PROT_QUARTER_FROM;
            2'b10: a = `PROT_HALF_FROM;
            default: a = `PROT_ALL_FROM;
        endcase
        return a;
    endfunction : levelFrom

    logic                        rstMeta;
    logic                        rstN;
    flash_spi_pkg::pinSample_t   rawPins;
    flash_spi_pkg::pinSample_t   pins;
    logic                        sckPrev;
    logic                        selNPrev;
    logic                        paused;
    flash_spi_pkg::seqState_t    state;
    flash_spi_pkg::seqState_t    next_state;
    logic [2:0]                  bitCount;
    logic [6:0]                  rxShift;
    logic [6:0]                  txShift;
    logic [2:0]                  txCount;
    logic                        txStarted;
    logic                        hwGuard;
    logic [1:0]                  level;
    logic                        wel;
    logic [CW-1:0]               busyCount;
    logic                        pendingStatus;
    logic [7:0]                  statusData;
    logic                        pendingArray;

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    assign rawPins = '{selectN: select_n, sck: sck, mosi: mosi,
                       pauseN: pause_n, guardN: write_guard_n};

    pin_sync #(
        .WIDTH   ($bits(flash_spi_pkg::pinSample_t)),
        .RST_VAL (PIN_RST)
    ) u_pin_sync (
        .clk  (clk),
        .rstN (rstN),
        .din  (rawPins),
        .dout (pins)
    );

    // edge detection and qualifiers
    wire        selected  = ~pins.selectN;
    wire        selFall   = selected & selNPrev;
    wire        selRise   = pins.selectN & ~selNPrev;
    wire        sckRise   = pins.sck & ~sckPrev;
    wire        sckFall   = ~pins.sck & sckPrev;
    wire        running   = selected & ~selFall & ~paused;
    wire        takeBit   = running & sckRise & (state != flash_spi_pkg::ST_DEAD);
    wire        byteDone  = takeBit & (bitCount == 3'h7);
    wire [7:0]  rxByte    = {rxShift, pins.mosi};
    wire        busy      = (busyCount != '0);
    wire        hwGuarded = ~pins.guardN & hwGuard;
    wire [7:0]  statusNow = packStatus(hwGuard, level, wel, busy);
    wire        opDone    = byteDone & (state == flash_spi_pkg::ST_OPCODE);

    // pause follows the pin only while sck is low
    wire        next_paused = selected & (pins.sck ? paused : ~pins.pauseN);

    // opcode decode
    wire isSetLatch  = (rxByte == `OP_SET_WRITE_LATCH);
    wire isClrLatch  = (rxByte == `OP_CLEAR_WRITE_LATCH);
    wire isStatRead  = (rxByte == `OP_STATUS_READ);
    wire isStatWrite = (rxByte == `OP_STATUS_WRITE);
    wire isRead      = (rxByte == `OP_ARRAY_READ) |
                       (rxByte == `OP_ARRAY_FAST_READ);
    wire isProgram   = (rxByte == `OP_PAGE_PROGRAM);
    wire isWipe      = (rxByte == `OP_PAGE_WIPE) | (rxByte == `OP_SECTOR_WIPE) |
                       (rxByte == `OP_FULL_WIPE);
    wire isGuardIn   = (rxByte == `OP_SOFT_GUARD_ENTER);
    wire isGuardOut  = (rxByte == `OP_SOFT_GUARD_EXIT);
    wire isKnown     = isSetLatch | isClrLatch | isStatRead | isStatWrite | isRead |
                       isProgram | isWipe | isGuardIn | isGuardOut;
    wire accept      = opDone & isKnown & (~busy | isStatRead);
    wire arrayOp     = isProgram | isWipe;

    // status write gating and commit
    wire statLoad    = byteDone & (state == flash_spi_pkg::ST_STAT_IN) &
                       wel & ~hwGuarded;
    wire statAbort   = pendingStatus & selected & hwGuarded;
    wire statCommit  = selRise & pendingStatus;
    wire arrayGo     = selRise & pendingArray & ~busy;

    // sequence state machine
    always_comb
    begin
        next_state = state;
        unique case (state)
            flash_spi_pkg::ST_OPCODE:
            begin
                if (opDone)
                begin
                    if (!isKnown)
                        next_state = flash_spi_pkg::ST_DEAD;
                    else if (busy && !isStatRead)
                        next_state = flash_spi_pkg::ST_IGNORE;
                    else if (isStatRead)
                        next_state = flash_spi_pkg::ST_STAT_OUT;
                    else if (isStatWrite)
                        next_state = flash_spi_pkg::ST_STAT_IN;
                    else
                        next_state = flash_spi_pkg::ST_IGNORE;
                end
            end
            flash_spi_pkg::ST_STAT_IN:
            begin
                if (byteDone)
                    next_state = flash_spi_pkg::ST_IGNORE;
            end
            flash_spi_pkg::ST_STAT_OUT,
            flash_spi_pkg::ST_IGNORE,
            flash_spi_pkg::ST_DEAD:
                next_state = state;
            default:
                next_state = flash_spi_pkg::ST_OPCODE;
        endcase
        if (!selected || selFall)
            next_state = flash_spi_pkg::ST_OPCODE;
    end

    // sampled history and sequence
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            sckPrev  <= 1'b0;
            selNPrev <= 1'b1;
            paused   <= 1'b0;
            state    <= flash_spi_pkg::ST_OPCODE;
        end
        else
        begin
            sckPrev  <= pins.sck;
            selNPrev <= pins.selectN;
            paused   <= next_paused;
            state    <= next_state;
        end
    end

    // input shifter and bit counter
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            bitCount <= 3'h0;
            rxShift  <= 7'h00;
        end
        else if (selFall || !selected)
        begin
            bitCount <= 3'h0;
            rxShift  <= 7'h00;
        end
        else if (takeBit)
        begin
            bitCount <= bitCount + 3'h1;
            rxShift  <= rxByte[6:0];
        end
    end

    // status byte output on falling sck
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            miso      <= 1'b0;
            txShift   <= 7'h00;
            txCount   <= 3'h0;
            txStarted <= 1'b0;
        end
        else if (selFall || !selected)
        begin
            txCount   <= 3'h0;
            txStarted <= 1'b0;
        end
        else if (running && sckFall && state == flash_spi_pkg::ST_STAT_OUT)
        begin
            txStarted <= 1'b1;
            txCount   <= txCount + 3'h1;
            if (txCount == 3'h0)
            begin
                miso    <= statusNow[7];
                txShift <= statusNow[6:0];
            end
            else
            begin
                miso    <= txShift[6];
                txShift <= {txShift[5:0], 1'b0};
            end
        end
    end

    // enable is low only while driving the status byte
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            misoOe <= 1'b1;
        else
            misoOe <= ~(selected & ~next_paused & txStarted &
                        (state == flash_spi_pkg::ST_STAT_OUT));
    end

    // pending status and array actions
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            pendingStatus <= 1'b0;
            statusData    <= `STATUS_RESET;
            pendingArray  <= 1'b0;
            arrayOpcode   <= 8'h00;
        end
        else
        begin
            if (statLoad)
            begin
                pendingStatus <= 1'b1;
                statusData    <= rxByte;
            end
            else if (statAbort || statCommit || selFall)
                pendingStatus <= 1'b0;
            if (accept && arrayOp && wel && !busy)
            begin
                pendingArray <= 1'b1;
                arrayOpcode  <= rxByte;
            end
            else if (selRise || selFall)
                pendingArray <= 1'b0;
        end
    end

    // status register fields and busy timer
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            hwGuard   <= 1'(`STATUS_RESET >> `ST_HW_GUARD_BIT);
            level     <= 2'b00;
            wel       <= 1'b0;
            busyCount <= '0;
            softGuard <= 1'b0;
        end
        else
        begin
            if (statCommit)
            begin
                hwGuard <= statusData[`ST_HW_GUARD_BIT];
                level   <= {statusData[`ST_LEVEL_HI_BIT],
                            statusData[`ST_LEVEL_LO_BIT]};
                wel     <= 1'b0;
            end
            else if (accept && isSetLatch)
                wel <= 1'b1;
            else if (accept && isClrLatch)
                wel <= 1'b0;
            else if (busyCount == CW'(1))
                wel <= 1'b0;
            if (arrayGo)
                busyCount <= CW'(BUSY_CYCLES);
            else if (busy)
                busyCount <= busyCount - CW'(1);
            if (accept && isGuardIn)
                softGuard <= 1'b1;
            else if (accept && isGuardOut)
                softGuard <= 1'b0;
        end
    end

    // registered views for the array side
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            statusByte  <= `STATUS_RESET;
            arrayStart  <= 1'b0;
            protectAny  <= 1'b0;
            protectFrom <= `PROT_ALL_FROM;
        end
        else
        begin
            statusByte  <= statusNow;
            arrayStart  <= arrayGo;
            protectAny  <= (level != 2'b00);
            protectFrom <= levelFrom(level);
        end
    end
endmodule : serial_flash_spi_front_end

// ---- dv/serial_flash_spi_props.sv ----
// port assertions for the serial flash front end
// assumes it is bound onto serial_flash_spi_front_end
module serial_flash_spi_props #(
    parameter int BUSY_CYCLES = 50
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        select_n,
    input wire logic        sck,
    input wire logic        mosi,
    input wire logic        pause_n,
    input wire logic        write_guard_n,
    input wire logic        miso,
    input wire logic        misoOe,
    input wire logic [7:0]  statusByte,
    input wire logic        arrayStart,
    input wire logic [7:0]  arrayOpcode,
    input wire logic        protectAny,
    input wire logic [17:0] protectFrom,
    input wire logic        softGuard
);
    timeunit 1ns;
    timeprecision 1ps;
    int          busyRun;
    logic [17:0] levelFrom;

    // lowest guarded address for the current level bits
    assign levelFrom = statusByte[3] ? (statusByte[2] ? 18'h00000 : 18'h20000)
                                     : (statusByte[2] ? 18'h30000 : 18'h00000);

    // length of the current busy stretch
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            busyRun <= 0;
        else
            busyRun <= statusByte[0] ? busyRun + 1 : 0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_deselect_floats: assert property (select_n [*6] |-> misoOe)
        else $error("output driven while deselected");
    a_pause_floats: assert property ((!pause_n && !sck) [*6] |-> misoOe)
        else $error("output driven while paused");
    a_miso_on_fall: assert property (!misoOe && !select_n && $changed(miso) |-> !sck)
        else $error("output changed with clock high");
    a_zero_bits: assert property (statusByte[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    a_busy_latch: assert property (statusByte[0] |-> statusByte[1])
        else $error("busy without latch bit");
    a_start_busy: assert property (arrayStart |-> ##[0:3] statusByte[0])
        else $error("busy not raised after start");
    a_start_ready: assert property (arrayStart |->
        $past(statusByte[1]) && !$past(statusByte[0]))
        else $error("start while busy or without latch");
    a_busy_length: assert property ($fell(statusByte[0]) |->
        $past(busyRun) >= BUSY_CYCLES - 2 && $past(busyRun) <= BUSY_CYCLES + 2)
        else $error("busy length wrong");
    a_level_map: assert property ($stable(statusByte) |->
        protectAny == (statusByte[3:2] != 2'h0) && protectFrom == levelFrom)
        else $error("protect range mismatch");
    a_fields_deselect: assert property ($changed(statusByte[7:2]) |-> select_n)
        else $error("status fields changed mid frame");
    a_guard_blocks: assert property ((!write_guard_n && statusByte[7]) [*8] |=>
        $stable(statusByte[7:2]))
        else $error("status written while guarded");

    c_status_out: cover property ($fell(misoOe));
    c_wipe_start: cover property (arrayStart);
    c_busy_end: cover property ($fell(statusByte[0]));
endmodule : serial_flash_spi_props

bind serial_flash_spi_front_end serial_flash_spi_props #(.BUSY_CYCLES(BUSY_CYCLES))
    u_serial_flash_spi_props (.clk(clk), .resetn(resetn), .select_n(select_n),
    .sck(sck), .mosi(mosi), .pause_n(pause_n), .write_guard_n(write_guard_n),
    .miso(miso), .misoOe(misoOe), .statusByte(statusByte), .arrayStart(arrayStart),
    .arrayOpcode(arrayOpcode), .protectAny(protectAny), .protectFrom(protectFrom),
    .softGuard(softGuard));

// ---- dv/spi_master_model.sv ----
// behavioural spi master driving the flash front end pins
// assumes the caller runs its tasks from the falling clk edge
module spi_master_model (
    input  wire logic clk,
    input  wire logic miso,
    input  wire logic misoOe,
    output logic      select_n,
    output logic      sck,
    output logic      mosi,
    output logic      pause_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 20; // 80 ns half period at 4 ns clk
    logic mode3;
    logic oeSeen;

    // idle pins: deselected, pause unused
    initial
    begin
        select_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        pause_n = 1'b1;
        mode3 = 1'b0;
        oeSeen = 1'b0;
    end

    task automatic half();
        repeat (HALF) @(negedge clk);
    endtask : half

    // park clock by mode, then select
    task automatic open_frame(input logic m3);
        mode3 = m3;
        sck = m3;
        half();
        select_n = 1'b0;
        oeSeen = 1'b0;
        half();
    endtask : open_frame

    // one byte msb first, miso taken at each rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            mosi = tx[i];
            half();
            sck = 1'b1;
            rx[i] = miso;
            oeSeen = oeSeen | (misoOe === 1'b0);
            half();
        end
        sck = 1'b0;
        half();
    endtask : xfer

    // pause with clock low, wiggle the pins, then resume
    task automatic hold_span(output logic oeLow);
        pause_n = 1'b0;
        half();
        sck = 1'b1;
        mosi = ~mosi;
        half();
        sck = 1'b0;
        half();
        oeLow = (misoOe !== 1'b1);
        pause_n = 1'b1;
        half();
    endtask : hold_span

    // deselect; released data line flips
    task automatic close_frame();
        sck = mode3;
        half();
        select_n = 1'b1;
        mosi = ~mosi;
        half();
        half();
    endtask : close_frame
endmodule : spi_master_model

// ---- dv/tb_serial_flash_spi_front_end.sv ----
// self-checking bench for the serial flash front end
// assumes the master model and the bound checker are compiled
module tb_serial_flash_spi_front_end;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY = 2000;
    logic        clk;
    logic        resetn;
    logic        write_guard_n;
    logic        select_n;
    logic        sck;
    logic        mosi;
    logic        pause_n;
    logic        miso;
    logic        misoOe;
    logic [7:0]  statusByte;
    logic        arrayStart;
    logic [7:0]  arrayOpcode;
    logic        protectAny;
    logic [17:0] protectFrom;
    logic        softGuard;
    int          n_errors;
    int          samples_checked;
    int          starts;
    logic [7:0]  rx;
    logic        oeLow;
    logic [17:0] fromTab [4] = '{18'h00000, 18'h30000, 18'h20000, 18'h00000};
    logic [7:0]  wipeOps [4] = '{8'h81, 8'hD8, 8'hC7, 8'h02};

    serial_flash_spi_front_end #(.BUSY_CYCLES(BUSY)) u_serial_flash_spi_front_end (
        .clk(clk), .resetn(resetn), .select_n(select_n), .sck(sck), .mosi(mosi),
        .pause_n(pause_n), .write_guard_n(write_guard_n), .miso(miso), .misoOe(misoOe),
        .statusByte(statusByte), .arrayStart(arrayStart), .arrayOpcode(arrayOpcode),
        .protectAny(protectAny), .protectFrom(protectFrom), .softGuard(softGuard));
    spi_master_model u_spi_master_model (.clk(clk), .miso(miso), .misoOe(misoOe),
        .select_n(select_n), .sck(sck), .mosi(mosi), .pause_n(pause_n));

    always #2 clk = ~clk;
    // count start pulses
    always @(posedge clk)
        if (arrayStart === 1'b1)
            starts = starts + 1;

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // one frame: opcode, optional data byte
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic withData);
        u_spi_master_model.open_frame(1'b0);
        u_spi_master_model.xfer(op, rx);
        if (withData)
            u_spi_master_model.xfer(d, rx);
        u_spi_master_model.close_frame();
    endtask : cmd

    // status read, byte given twice
    task automatic status_read_cmd(input logic m3, input logic [7:0] exp, input logic [7:0] mask);
        logic [7:0] rx2;
        u_spi_master_model.open_frame(m3);
        u_spi_master_model.xfer(8'h05, rx);
        u_spi_master_model.xfer(8'hA5, rx);
        u_spi_master_model.xfer(8'h5A, rx2);
        u_spi_master_model.close_frame();
        check(18'(rx & mask), 18'(exp & mask));
        check(18'(rx2 & mask), 18'(exp & mask));
    endtask : status_read_cmd

    task automatic t_status_write();
        cmd(8'h06, 8'h00, 1'b0);
        status_read_cmd(1'b0, 8'h02, 8'hFF);
        cmd(8'h04, 8'h00, 1'b0);
        status_read_cmd(1'b0, 8'h00, 8'hFF);
        cmd(8'h06, 8'h00, 1'b0);
        cmd(8'h01, 8'hFF, 1'b1);
        status_read_cmd(1'b0, 8'h8C, 8'hFF);
        for (int l = 0; l < 4; l++)
        begin
            cmd(8'h06, 8'h00, 1'b0);
            cmd(8'h01, {4'h0, 2'(l), 2'h0}, 1'b1);
            check(18'(protectAny), 18'(l != 0));
            check(protectFrom, fromTab[l]);
        end
    endtask : t_status_write

    task automatic t_soft_guard();
        cmd(8'hB9, 8'h00, 1'b0);
        check(18'(softGuard), 18'h1);
        cmd(8'hAB, 8'h00, 1'b0);
        check(18'(softGuard), 18'h0);
    endtask : t_soft_guard

    task automatic t_unknown_and_pause();
        u_spi_master_model.open_frame(1'b0);
        u_spi_master_model.xfer(8'h5A, rx);
        u_spi_master_model.xfer(8'h05, rx);
        u_spi_master_model.xfer(8'hA5, rx);
        u_spi_master_model.close_frame();
        check(18'(u_spi_master_model.oeSeen), 18'h0);
        u_spi_master_model.open_frame(1'b0);
        u_spi_master_model.xfer(8'h05, rx);
        u_spi_master_model.hold_span(oeLow);
        check(18'(oeLow), 18'h0);
        u_spi_master_model.xfer(8'h00, rx);
        u_spi_master_model.close_frame();
        check(18'(rx), 18'h0C);
        status_read_cmd(1'b1, 8'h0C, 8'hFF);
    endtask : t_unknown_and_pause

    task automatic t_guard();
        write_guard_n = 1'b0;
        cmd(8'h06, 8'h00, 1'b0);
        cmd(8'h01, 8'h80, 1'b1);
        check(18'(statusByte), 18'h80);
        cmd(8'h06, 8'h00, 1'b0);
        cmd(8'h01, 8'h0C, 1'b1);
        check(18'(statusByte[7:2]), 18'h20);
        write_guard_n = 1'b1;
        cmd(8'h06, 8'h00, 1'b0);
        u_spi_master_model.open_frame(1'b0);
        u_spi_master_model.xfer(8'h01, rx);
        u_spi_master_model.xfer(8'h0C, rx);
        write_guard_n = 1'b0;
        u_spi_master_model.close_frame();
        check(18'(statusByte[7:2]), 18'h20);
        write_guard_n = 1'b1;
        cmd(8'h06, 8'h00, 1'b0);
        cmd(8'h01, 8'h00, 1'b1);
        check(18'(statusByte), 18'h00);
    endtask : t_guard

    task automatic t_wipe();
        for (int k = 0; k < 4; k++)
        begin
            starts = 0;
            cmd(8'h06, 8'h00, 1'b0);
            cmd(wipeOps[k], 8'h00, 1'b0);
            check(18'(arrayOpcode), 18'(wipeOps[k]));
            check(18'(starts), 18'h1);
            status_read_cmd(1'b0, 8'h03, 8'h03);
            cmd(8'hB9, 8'h00, 1'b0);
            check(18'(softGuard), 18'h0);
            for (int w = 0; w < 4000 && statusByte[0] !== 1'b0; w++)
                @(negedge clk);
            check(18'(statusByte[1:0]), 18'h0);
        end
        starts = 0;
        cmd(8'hD8, 8'h00, 1'b0);
        check(18'(starts), 18'h0);
        cmd(8'h06, 8'h00, 1'b0);
        cmd(8'h03, 8'h00, 1'b0);
        cmd(8'h0B, 8'h00, 1'b0);
        check(18'(starts), 18'h0);
        check(18'(statusByte[1]), 18'h1);
    endtask : t_wipe

    task automatic results();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // reset, then scenarios in order
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        write_guard_n = 1'b1;
        n_errors = 0;
        samples_checked = 0;
        starts = 0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        check(18'(statusByte), 18'h00);
        check(18'(misoOe), 18'h1);
        t_status_write();
        t_soft_guard();
        t_unknown_and_pause();
        t_guard();
        t_wipe();
        results();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule : tb_serial_flash_spi_front_end
